// file: core/realtime_clock_alarm.sv
// Real-time clock with tick divider, time counter and alarm
// Overview: a source is chosen once after reset. Its ticks feed a
// fixed divide-by-64 prescaler and a 20-bit reloadable divider, whose
// joint roll-over is the basic tick. The basic tick advances the 32-bit
// time counter and the n-tick counter and may set the tick request.
// The alarm request is raised on the first cycle of equality between
// the time counter and the alarm value.
//
// Limitations: the source choice is fixed until the next reset, so a
// crystal that starts late is never picked up. The detection window is
// measured in clock_i cycles, so its length in time scales with the
// system clock. Requests are levels that software clears; the external
// lines and the wake request follow them in the same registered cycle.
//
// Power-down: the counter runs only when run_in_powerdown is set and
// oscillator_off_bit is clear; otherwise it holds its value. Gating of
// the oscillators only acts while powerdown_i is high.
`timescale 1ns/1ns
`default_nettype none
`include "rtc_consts.svh"
module realtime_clock_alarm (
  input wire logic clock_i, // Main clock, 100 MHz
  input wire logic reset_n_i, // Asynchronous reset, active low
  input wire logic main_osc_tick_i, // Main oscillator input, enable pulse
  input wire logic low_power_osc_input_i, // 32 kHz oscillator pin level
  input wire logic powerdown_i, // Chip is in power-down
  input wire logic powerdown_wake_config_i, // System config wake enable
  input wire logic [1:0] external_irq_select_i, // Bit0 tick, bit1 alarm
  input wire rtc_pkg::timekeeper_control_t timekeeper_control_i, // Control
  input wire logic [19:0] tick_period_reload_i, // Divider reload value
  input wire logic [15:0] ntick_count_i, // n for cyclic interrupt
  input wire logic time_load_i, // Strobe: load time counter
  input wire logic [31:0] time_load_value_i, // Value to load
  input wire logic [31:0] alarm_value_i, // Alarm register
  input wire logic irq_clear_i, // Strobe: clear all requests
  output logic [57:0] long_timer_o, // Whole prescaler chain and counter
  output logic [31:0] time_o, // Time counter
  output rtc_pkg::irq_t irq_o, // Sticky interrupt requests
  output logic [1:0] external_irq_o, // Requests to port external irq path
  output logic wake_o, // Wake request from power-down
  output logic low_power_selected_o, // 32 kHz source in use
  output logic main_osc_enable_o, // Main oscillator enable
  output logic low_power_osc_enable_o // 32 kHz oscillator enable
);
  // Three-stage synchroniser for the 32 kHz pin. The pin is asynchronous
  // to clock_i, so the first stage may go metastable; only the second
  // stage reads it.
  logic sync1, sync2, sync3;
  logic next_sync1, next_sync2, next_sync3;
  always_comb begin
    next_sync1 = low_power_osc_input_i;
    next_sync2 = sync1;
    next_sync3 = sync2;
  end
  // Reset to the idle low level of the pin, so no false rise follows reset
  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      sync1 <= 1'b0;
      sync2 <= 1'b0;
      sync3 <= 1'b0;
    end else begin
      sync1 <= next_sync1;
      sync2 <= next_sync2;
      sync3 <= next_sync3;
    end
  end
  // A level change counts once the second and third stages agree, which
  // filters a single-cycle glitch that a slow crystal edge can leave
  // behind. A rise of that filtered level is one 32 kHz tick.
  logic lp_state, next_lp_state;
  logic lp_edge;
  always_comb begin
    next_lp_state = lp_state;
    if (sync2 == sync3) begin
      next_lp_state = sync3;
    end
  end
  assign lp_edge = next_lp_state & ~lp_state;

  // Source detection after reset
  // Counts synchronised rises in a fixed window after reset. Eight rises
  // pick the low-power source; a closed window with fewer picks the main
  // oscillator. The choice holds until the next reset.
  rtc_pkg::src_state_t state, next_state;
  logic [15:0] det_cnt, next_det_cnt;
  logic [3:0] edge_cnt, next_edge_cnt;
  always_comb begin
    next_state = state;
    next_det_cnt = det_cnt;
    next_edge_cnt = edge_cnt;
    unique case (state)
      rtc_pkg::ST_DETECT: begin
        next_det_cnt = det_cnt + 16'h0001;
        if (lp_edge) begin
          next_edge_cnt = edge_cnt + 4'h1;
        end
        if (edge_cnt == `RTC_DETECT_EDGES) begin
          next_state = rtc_pkg::ST_LOW_POWER;
        end else if (det_cnt == `RTC_DETECT_WINDOW) begin
          next_state = rtc_pkg::ST_MAIN;
        end
      end
      rtc_pkg::ST_LOW_POWER: next_state = state;
      rtc_pkg::ST_MAIN: next_state = state;
      default: next_state = rtc_pkg::ST_DETECT;
    endcase
  end
  // Register detection state and the filtered pin level
  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      state <= rtc_pkg::ST_DETECT;
      det_cnt <= 16'h0000;
      edge_cnt <= 4'h0;
      lp_state <= 1'b0;
    end else begin
      state <= next_state;
      det_cnt <= next_det_cnt;
      edge_cnt <= next_edge_cnt;
      lp_state <= next_lp_state;
    end
  end

  // Source clock enable pulse and run condition. Detection must finish
  // before the counter runs, so ticks seen while the source is still
  // unknown are dropped rather than counted at the wrong rate.
  logic use_lp, src_tick, run;
  assign use_lp = (state == rtc_pkg::ST_LOW_POWER);
  assign src_tick = use_lp ? lp_edge : main_osc_tick_i;
  // In power-down the counter runs only if allowed
  assign run = timekeeper_control_i.enable &&
    (state != rtc_pkg::ST_DETECT) &&
    (!powerdown_i || (timekeeper_control_i.run_in_powerdown &&
      !timekeeper_control_i.oscillator_off_bit));

  // Prescaler chain, divider and time counter
  // pre divides the source by 64; div counts down from the reload value
  // and the basic tick falls where both roll over. A reload of r gives a
  // period of 64 * (r + 1) source ticks. The reload is taken only at the
  // roll-over, so a new period starts cleanly after the current one.
  // A software load wins over a tick in the same cycle.
  logic [5:0] pre, next_pre;
  logic [19:0] div, next_div;
  logic [31:0] tcount, next_tcount;
  logic [15:0] ncnt, next_ncnt;
  logic basic_tick;
  assign basic_tick = run && src_tick && (pre == `RTC_PRE_DIV) &&
    (div == 20'h00000);
  always_comb begin
    next_pre = pre;
    next_div = div;
    next_tcount = tcount;
    next_ncnt = ncnt;
    if (run && src_tick) begin
      next_pre = pre + 6'h01;
      if (pre == `RTC_PRE_DIV) begin
        if (div == 20'h00000) begin
          next_div = tick_period_reload_i;
        end else begin
          next_div = div - 20'h00001;
        end
      end
    end
    if (basic_tick) begin
      next_tcount = tcount + 32'h00000001; // Wraps to zero
      if (ncnt == 16'h0000) begin
        next_ncnt = ntick_count_i;
      end else begin
        next_ncnt = ncnt - 16'h0001;
      end
    end
    if (time_load_i) begin
      next_tcount = time_load_value_i; // Software initialise
    end
  end
  // Register the counter chain
  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      pre <= 6'h00;
      div <= 20'h00000;
      tcount <= 32'h00000000;
      ncnt <= 16'h0000;
    end else begin
      pre <= next_pre;
      div <= next_div;
      tcount <= next_tcount;
      ncnt <= next_ncnt;
    end
  end

  // Interrupt requests are sticky until irq_clear_i. A set in the same
  // cycle as a clear wins, so no event is lost to a late clear.
  // The alarm edge is remembered so a lasting match fires only once.
  rtc_pkg::irq_t irq, next_irq;
  logic set_tick, set_ntick, set_alarm;
  logic alarm_hit, alarm_hit_q, next_alarm_hit_q;
  assign alarm_hit = (tcount == alarm_value_i);
  assign set_tick = basic_tick &&
    timekeeper_control_i.tick_irq_en;
  // n-tick fires when its counter is zero at a tick: period of n + 1
  assign set_ntick = basic_tick && timekeeper_control_i.ntick_irq_en &&
    (ncnt == 16'h0000);
  // Alarm fires on the first cycle of a match, not every cycle of it
  assign set_alarm = alarm_hit && !alarm_hit_q &&
    timekeeper_control_i.alarm_irq_en;
  always_comb begin
    next_irq = irq;
    next_alarm_hit_q = alarm_hit;
    if (irq_clear_i) begin
      next_irq = '0;
    end
    if (set_tick) begin
      next_irq.tick_interrupt_request = 1'b1;
    end
    if (set_ntick) begin
      next_irq.ntick_interrupt_request = 1'b1;
    end
    if (set_alarm) begin
      next_irq.alarm_interrupt_request = 1'b1;
    end
  end

  // External irq routing, wake and oscillator gating
  logic [1:0] next_ext;
  logic next_wake, next_main_en, next_lp_en;
  logic next_lp_sel;
  logic [31:0] next_time;
  logic [57:0] next_long;
  // Oscillator gating only acts in power-down; outside it both run so
  // detection and software always see a live source
  always_comb begin
    // Tick path carries both the tick and n-tick requests
    next_ext[0] = external_irq_select_i[0] &&
      (next_irq.tick_interrupt_request || next_irq.ntick_interrupt_request);
    next_ext[1] = external_irq_select_i[1] &&
      next_irq.alarm_interrupt_request;
    next_wake = powerdown_i && powerdown_wake_config_i &&
      (next_ext != 2'b00);
    next_main_en = 1'b1;
    next_lp_en = 1'b1;
    if (powerdown_i) begin
      if (!timekeeper_control_i.enable) begin
        next_main_en = 1'b0;
        next_lp_en = 1'b0;
      end else if (use_lp) begin
        next_main_en = 1'b0;
        next_lp_en = !timekeeper_control_i.oscillator_off_bit;
      end else begin // Main source runs unless oscillator_off_bit is set
        next_main_en = !timekeeper_control_i.oscillator_off_bit;
      end
    end
    // Status outputs follow the next detection state and the counter chain's next values
    next_lp_sel = (next_state == rtc_pkg::ST_LOW_POWER);
    next_time = next_tcount;
    next_long = {next_tcount, next_div, next_pre};
  end
  // Register requests and every top-level output
  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      irq <= '0;
      alarm_hit_q <= 1'b0;
      external_irq_o <= 2'b00;
      wake_o <= 1'b0;
      main_osc_enable_o <= 1'b1;
      low_power_osc_enable_o <= 1'b1;
      low_power_selected_o <= 1'b0;
      time_o <= 32'h00000000;
      long_timer_o <= 58'h000000000000000;
    end else begin
      irq <= next_irq;
      alarm_hit_q <= next_alarm_hit_q;
      external_irq_o <= next_ext;
      wake_o <= next_wake;
      main_osc_enable_o <= next_main_en;
      low_power_osc_enable_o <= next_lp_en;
      low_power_selected_o <= next_lp_sel;
      time_o <= next_time; // Software-visible state
      long_timer_o <= next_long;
    end
  end
  // irq is itself a register, so irq_o comes straight from a flop
  assign irq_o = irq;
endmodule : realtime_clock_alarm
`default_nettype wire

// file: include/rtc_consts.svh
// Constants for the real-time clock block
`ifndef RTC_CONSTS_SVH
`define RTC_CONSTS_SVH
`define RTC_PRE_DIV 6'h3F
`define RTC_PERIOD_W 20
`define RTC_TIME_W 32
`define RTC_NTICK_W 16
`define RTC_DETECT_WINDOW 16'hFFFF
`define RTC_DETECT_EDGES 4'h8
`endif

// file: include/rtc_pkg.sv
// Types for the real-time clock block
package rtc_pkg;
  typedef struct packed {
    logic enable;
    logic run_in_powerdown;
    logic oscillator_off_bit;
    logic tick_irq_en;
    logic ntick_irq_en;
    logic alarm_irq_en;
  } timekeeper_control_t;

  typedef struct packed {
    logic tick_interrupt_request;
    logic ntick_interrupt_request;
    logic alarm_interrupt_request;
  } irq_t;

  typedef enum logic [2:0] {
    ST_DETECT = 3'h1,
    ST_LOW_POWER = 3'h2,
    ST_MAIN = 3'h4
  } src_state_t;
endpackage : rtc_pkg

// file: test/osc_model.sv
// Oscillator model feeding the clock block's source inputs
`timescale 1ns/1ns
`default_nettype none
module osc_model (
  input wire logic clock_i, // System clock
  input wire logic osc_enable_i, // Main oscillator enable
  input wire logic lp_fitted_i, // A 32 kHz crystal is fitted
  output logic osc_tick_o, // One pulse per oscillator edge
  output logic lp_pin_o // Low-power pin
);
  logic [1:0] lp_div = 2'h0;
  // A fitted crystal toggles the pin every 4 clocks, a rise every 8
  always_ff @(posedge clock_i) begin
    lp_div <= lp_div + 2'h1;
    if (!lp_fitted_i) begin
      lp_pin_o <= 1'b0;
    end else if (lp_div == 2'h3) begin
      lp_pin_o <= ~lp_pin_o;
    end
  end
  // A gated oscillator gives no edges, so nothing counts while it is off
  always_ff @(posedge clock_i) begin
    osc_tick_o <= osc_enable_i;
  end
endmodule : osc_model
`default_nettype wire

// file: test/realtime_clock_alarm_properties.sv
// Port checks for the real-time clock block
`timescale 1ns/1ns
`default_nettype none
module realtime_clock_alarm_properties (
  input wire logic clock_i, // Clock
  input wire logic reset_n_i, // Reset, active low
  input wire logic powerdown_i, // Power-down
  input wire logic powerdown_wake_config_i, // Wake enable
  input wire logic [1:0] external_irq_select_i, // Routing
  input wire rtc_pkg::timekeeper_control_t timekeeper_control_i, // Control
  input wire logic time_load_i, // Load strobe
  input wire logic [31:0] time_load_value_i, // Load value
  input wire logic [31:0] alarm_value_i, // Alarm
  input wire logic [31:0] time_o, // Time counter
  input wire rtc_pkg::irq_t irq_o, // Requests
  input wire logic [1:0] external_irq_o, // External lines
  input wire logic wake_o, // Wake
  input wire logic low_power_selected_o, // 32 kHz source in use
  input wire logic main_osc_enable_o, // Main osc on
  input wire logic low_power_osc_enable_o // Low-power osc on
);
  default clocking @(posedge clock_i); endclocking
  default disable iff (!reset_n_i);
  // Halted in power-down: oscillator off or not allowed to run
  sequence pd_halted;
    powerdown_i && !time_load_i && (timekeeper_control_i.oscillator_off_bit
      || !timekeeper_control_i.run_in_powerdown);
  endsequence
  sequence counted;
    $changed(time_o) && !$past(time_load_i);
  endsequence
  a_load_takes_value: assert property (
    time_load_i |=> time_o == $past(time_load_value_i))
    else $error("time counter missed a load");
  a_count_steps_one: assert property (
    counted |-> time_o == 32'($past(time_o) + 32'h1))
    else $error("time counter did not step by one");
  a_alarm_on_match: assert property (
    $changed(time_o) && time_o == alarm_value_i
      && timekeeper_control_i.alarm_irq_en
      |-> ##[0:2] irq_o.alarm_interrupt_request)
    else $error("alarm request missing on match");
  a_tick_sets_request: assert property (
    counted and timekeeper_control_i.tick_irq_en
      |-> ##[0:2] irq_o.tick_interrupt_request)
    else $error("tick request missing");
  a_route_needs_select: assert property (
    (external_irq_o & ~$past(external_irq_select_i)) == 2'h0)
    else $error("external line raised without routing");
  a_wake_needs_config: assert property (
    wake_o |-> $past(powerdown_wake_config_i) && $past(powerdown_i))
    else $error("wake without wake config");
  a_disabled_osc_off: assert property (
    (powerdown_i && !timekeeper_control_i.enable) [*2]
      |-> !main_osc_enable_o && !low_power_osc_enable_o)
    else $error("oscillators left on while disabled");
  a_halted_count_stable: assert property (
    pd_halted [*3] |-> $stable(time_o))
    else $error("time counter moved while halted");
  a_lp_stops_main: assert property (
    low_power_selected_o && powerdown_i |=> !main_osc_enable_o)
    else $error("main oscillator left on with low-power source");
endmodule : realtime_clock_alarm_properties
bind realtime_clock_alarm realtime_clock_alarm_properties u_props (
  .clock_i(clock_i), .reset_n_i(reset_n_i), .powerdown_i(powerdown_i),
  .powerdown_wake_config_i(powerdown_wake_config_i),
  .external_irq_select_i(external_irq_select_i),
  .timekeeper_control_i(timekeeper_control_i), .time_load_i(time_load_i),
  .time_load_value_i(time_load_value_i), .alarm_value_i(alarm_value_i),
  .time_o(time_o), .irq_o(irq_o), .external_irq_o(external_irq_o),
  .wake_o(wake_o), .low_power_selected_o(low_power_selected_o),
  .main_osc_enable_o(main_osc_enable_o),
  .low_power_osc_enable_o(low_power_osc_enable_o));
`default_nettype wire

// file: test/realtime_clock_alarm_tb_top.sv
// Self-checking testbench for the real-time clock block
`timescale 1ns/1ns
`default_nettype none
module realtime_clock_alarm_tb_top;
  logic clock_i, reset_n_i, pd, cfg, load, clr, tick, lp_pin, m_en, lp_en;
  logic lp_sel, wake, a, lp_fit;
  logic [1:0] sel, ext;
  logic [19:0] reload;
  logic [15:0] n;
  logic [31:0] load_val, alarm, tm, t0;
  logic [57:0] long_t;
  rtc_pkg::timekeeper_control_t ctl;
  rtc_pkg::irq_t irq;
  int mismatches, checked, gap;
  realtime_clock_alarm u_dut (.clock_i(clock_i), .reset_n_i(reset_n_i),
    .main_osc_tick_i(tick), .low_power_osc_input_i(lp_pin),
    .powerdown_i(pd), .powerdown_wake_config_i(cfg),
    .external_irq_select_i(sel), .timekeeper_control_i(ctl),
    .tick_period_reload_i(reload), .ntick_count_i(n), .time_load_i(load),
    .time_load_value_i(load_val), .alarm_value_i(alarm), .irq_clear_i(clr),
    .long_timer_o(long_t), .time_o(tm), .irq_o(irq), .external_irq_o(ext),
    .wake_o(wake), .low_power_selected_o(lp_sel),
    .main_osc_enable_o(m_en), .low_power_osc_enable_o(lp_en));
  osc_model u_osc (.clock_i(clock_i), .osc_enable_i(m_en),
    .lp_fitted_i(lp_fit), .osc_tick_o(tick), .lp_pin_o(lp_pin));
  // Free-running 100 MHz clock
  initial begin
    clock_i = 1'b0;
    forever #5 clock_i = ~clock_i;
  end
  task automatic chk(input string nm, input logic [31:0] exp, got);
    checked++;
    if (got !== exp) begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  task automatic step(input int k);
    repeat (k) @(posedge clock_i);
    #1;
  endtask : step
  // Counts cycles to the next counter change; bounded so a stall shows
  task automatic wait_tick;
    t0 = tm;
    gap = 0;
    while (tm === t0 && gap < 5000) begin
      step(1);
      gap++;
    end
  endtask : wait_tick
  task automatic tally_and_finish;
    if (mismatches == 0 && checked > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : tally_and_finish
  // Watchdog: the tests need about 68000 cycles
  initial begin
    repeat (90000) @(posedge clock_i);
    mismatches++;
    tally_and_finish();
  end
  initial begin
    {reset_n_i, pd, cfg, load, clr, sel, reload, n} = '0;
    {load_val, alarm} = '0;
    ctl = '0;
    lp_fit = 1'b0;
    step(2);
    reset_n_i <= 1'b1;
    step(65540); // Detection window has closed
    chk("low_power_sel", 0, lp_sel);
    chk("main_osc_on", 1, m_en);
    ctl <= 6'h27;
    sel <= 2'h3;
    n <= 16'h0001;
    load_val <= 32'hFFFFFFFE;
    load <= 1'b1;
    step(1);
    load <= 1'b0;
    step(1);
    chk("loaded", 32'hFFFFFFFE, tm);
    wait_tick(); // First gap depends on the prescaler phase
    chk("all_ones", 32'hFFFFFFFF, tm);
    wait_tick();
    chk("gap_reload0", 64, gap);
    step(2);
    chk("wrapped", 0, tm);
    chk("alarm_req", 1, irq.alarm_interrupt_request);
    chk("ext_lines", 3, ext);
    chk("long_high", 0, long_t[57:26]);
    reload <= 20'h00002;
    wait_tick();
    wait_tick();
    chk("gap_reload2", 192, gap);
    chk("tick_req", 1, irq.tick_interrupt_request);
    // Alternate n-tick requests with n of one
    clr <= 1'b1;
    step(1);
    clr <= 1'b0;
    wait_tick();
    step(2);
    a = irq.ntick_interrupt_request;
    clr <= 1'b1;
    step(1);
    clr <= 1'b0;
    wait_tick();
    step(2);
    chk("ntick_alt", 1, a ^ irq.ntick_interrupt_request);
    ctl <= 6'h2F;
    pd <= 1'b1;
    cfg <= 1'b1;
    clr <= 1'b1;
    step(1);
    clr <= 1'b0;
    step(2);
    t0 = tm;
    step(400);
    chk("halted", t0, tm);
    chk("no_wake", 0, wake);
    ctl <= 6'h37;
    wait_tick();
    chk("runs_in_pd", 1, gap < 300);
    step(2);
    chk("wake", 1, wake);
    ctl <= 6'h17;
    step(3);
    chk("osc_off", 0, {m_en, lp_en});
    // Second reset with a crystal fitted: detection picks the 32 kHz pin
    lp_fit <= 1'b1;
    ctl <= 6'h2F;
    reset_n_i <= 1'b0;
    step(1);
    chk("reset_osc_on", 3, {m_en, lp_en});
    step(1);
    reset_n_i <= 1'b1;
    step(100);
    chk("low_power_sel2", 1, lp_sel);
    chk("lp_osc_off", 0, {m_en, lp_en});
    ctl <= 6'h37;
    wait_tick();
    chk("lp_runs", 1, gap < 2000);
    chk("lp_main_off", 2'h1, {m_en, lp_en});
    tally_and_finish();
  end
endmodule : realtime_clock_alarm_tb_top
`default_nettype wire
